// >>> logic/pmpa_cmd_core.sv
// command layer: channel select, paged block transfers, write protection, addressing
// assumes a byte-level bus front end that gives one-cycle event pulses synchronous to core_clk
`include "pmpa_regs.svh"
`default_nettype none

module pmpa_cmd_core
	import pmpa_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bus front end events
	input wire logic txn_start,
	input wire logic txn_rd,
	input wire logic [6:0] txn_addr,
	input wire logic txn_stop,
	input wire logic wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic rd_req,
	input wire logic rd_contention,
	// pins
	input wire logic protect_pin,
	input wire logic [3:0] addr_select_low_pin,
	input wire logic addr_select_low_open,
	input wire logic [2:0] addr_select_high_pin,
	input wire logic addr_select_high_open,
	// read data of commands held elsewhere
	input wire logic [7:0] ext_rd_data,
	// answers to the front end
	output logic addr_hit,
	output logic nack,
	output logic cml_fault,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// forwarded writes and current target
	output logic fwd_valid,
	output logic [7:0] fwd_data,
	output logic [7:0] tgt_code,
	output logic [1:0] tgt_mask
);
	// channel mask from a select value, zero for an unknown value
	function automatic logic [1:0] chan_mask(input logic [7:0] v);
		logic [1:0] m;
		m = 2'h0;
		if (v == `PMPA_CHAN_0) begin
			m = 2'h1;
		end else if (v == `PMPA_CHAN_1) begin
			m = 2'h2;
		end else if (v == `PMPA_CHAN_ALL) begin
			m = 2'h3;
		end
		return m;
	endfunction

	function automatic logic is_status(input logic [7:0] c);
		return (c >= `PMPA_CMD_STATUS_LO) && (c <= `PMPA_CMD_STATUS_HI);
	endfunction

	// commands that act on the selected channels; the codes listed act on the whole device
	function automatic logic is_paged(input logic [7:0] c);
		logic np;
		np = (c == `PMPA_CMD_CHAN_SEL) || (c == `PMPA_CMD_CLR_FAULTS) || (c == `PMPA_CMD_PB_WRITE) ||
			(c == `PMPA_CMD_PB_READ) || (c == `PMPA_CMD_WP_LEVEL) || (c == `PMPA_CMD_SAVE_NVM) ||
			(c == `PMPA_CMD_NVM_UNLOCK) || (c == `PMPA_CMD_GLOBAL_CFG) || (c == `PMPA_CMD_PEAK_RST) ||
			(c == `PMPA_CMD_DEV_ADDR) || (c == `PMPA_CMD_COMMON_STAT);
		return !np;
	endfunction

	// write permission from protect pin and protection level
	function automatic logic wr_allowed(input logic [7:0] c, input logic [7:0] wp, input logic pin);
		logic core;
		logic ctrl;
		logic vout;
		logic save;
		logic ok;
		core = (c == `PMPA_CMD_WP_LEVEL) || (c == `PMPA_CMD_CHAN_SEL) || (c == `PMPA_CMD_NVM_UNLOCK);
		ctrl = (c == `PMPA_CMD_OPERATION) || (c == `PMPA_CMD_PEAK_RST) || (c == `PMPA_CMD_CLR_FAULTS);
		vout = (c == `PMPA_CMD_ON_OFF_CFG) || (c == `PMPA_CMD_VOUT_SET);
		save = c == `PMPA_CMD_SAVE_NVM;
		if (pin) begin
			ok = core || ctrl || is_status(c);
		end else if (wp[`PMPA_WP_LOCK_BIT]) begin
			ok = core || save;
		end else if (wp[`PMPA_WP_CTRL_BIT]) begin
			ok = core || ctrl || save || is_status(c);
		end else if (wp[`PMPA_WP_VOUT_BIT]) begin
			ok = core || ctrl || vout || save || is_status(c);
		end else begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	pmpa_state_t state_reg;
	pmpa_state_t state_next;
	logic [7:0] chan_sel_reg;
	logic [7:0] wp_reg;
	logic [7:0] dev_addr_reg;
	logic [7:0] gcfg_reg;
	logic [7:0] ccfg_reg [2];
	logic [7:0] rail_reg [2];
	logic [1:0] rail_mask_reg;
	logic [1:0] pb_mask_reg;
	logic pb_mode_reg;
	logic pb_rd_reg;
	logic cnt_pend_reg;
	logic first_reg;

	logic hit;
	logic [1:0] rail_hit;

	// address match against straps, stored address, globals and rails
	pmpa_addr_match u_match (
		.txn_addr(txn_addr),
		.dev_addr_set(dev_addr_reg),
		.rail_addr_0(rail_reg[0]),
		.rail_addr_1(rail_reg[1]),
		.addr_select_low_pin(addr_select_low_pin),
		.addr_select_low_open(addr_select_low_open),
		.addr_select_high_pin(addr_select_high_pin),
		.addr_select_high_open(addr_select_high_open),
		.hit(hit),
		.rail_hit(rail_hit)
	);

	// target decode and write checks
	wire [1:0] cur_mask;
	wire [1:0] eff_mask;
	wire allowed;
	wire data_ev;
	wire code_ev;
	wire pb_ev;
	wire nest;
	wire chan_ok;
	wire deny;
	wire is_local;
	wire local_wr;
	wire pb_code;
	wire rd_ch1;
	wire [7:0] csb;
	wire [7:0] local_rd;

	assign cur_mask = pb_mode_reg ? pb_mask_reg : (|rail_mask_reg ? rail_mask_reg : chan_mask(chan_sel_reg));
	assign eff_mask = is_paged(tgt_code) ? cur_mask : 2'h3;
	assign allowed = wr_allowed(tgt_code, wp_reg, protect_pin);
	assign data_ev = wr_valid && (state_reg == ST_WDATA);
	assign code_ev = wr_valid && (state_reg == ST_CODE);
	assign pb_ev = wr_valid && (state_reg == ST_PB_CODE);
	assign pb_code = (wr_byte == `PMPA_CMD_PB_WRITE) || (wr_byte == `PMPA_CMD_PB_READ);
	assign nest = pb_ev && pb_code;
	assign chan_ok = chan_mask(wr_byte) != 2'h0;
	assign deny = data_ev && (!allowed || (tgt_code == `PMPA_CMD_CHAN_SEL && !chan_ok));
	assign is_local = (tgt_code == `PMPA_CMD_CHAN_SEL) || (tgt_code == `PMPA_CMD_WP_LEVEL) ||
		(tgt_code == `PMPA_CMD_DEV_ADDR) || (tgt_code == `PMPA_CMD_GLOBAL_CFG) ||
		(tgt_code == `PMPA_CMD_CHAN_CFG) || (tgt_code == `PMPA_CMD_RAIL_ADDR) ||
		(tgt_code == `PMPA_CMD_COMMON_STAT);
	assign local_wr = data_ev && !deny && first_reg && is_local;

	// read selection; with both channels selected channel 0 answers
	assign rd_ch1 = eff_mask == 2'h2;
	assign csb = 8'h01 << `PMPA_CSB_PIN_BIT;
	assign local_rd = (tgt_code == `PMPA_CMD_CHAN_SEL) ? chan_sel_reg :
		(tgt_code == `PMPA_CMD_WP_LEVEL) ? wp_reg :
		(tgt_code == `PMPA_CMD_DEV_ADDR) ? dev_addr_reg :
		(tgt_code == `PMPA_CMD_GLOBAL_CFG) ? gcfg_reg :
		(tgt_code == `PMPA_CMD_CHAN_CFG) ? ccfg_reg[rd_ch1] :
		(tgt_code == `PMPA_CMD_RAIL_ADDR) ? rail_reg[rd_ch1] :
		(tgt_code == `PMPA_CMD_COMMON_STAT) ? (protect_pin ? csb : 8'h00) : ext_rd_data;

	// transaction sequencing
	always_comb begin
		state_next = state_reg;
		if (txn_stop) begin
			state_next = ST_IDLE;
		end else if (txn_start) begin
			if (!hit) begin
				state_next = ST_DROP;
			end else if (!txn_rd) begin
				state_next = ST_CODE;
			end else if (state_reg == ST_WDATA && first_reg) begin
				state_next = ST_READ;
			end else begin
				state_next = ST_DROP;
			end
		end else if (wr_valid) begin
			case (state_reg)
				ST_CODE: begin
					state_next = pb_code ? ST_PB_CNT : ST_WDATA;
				end
				ST_PB_CNT: begin
					state_next = ST_PB_CHAN;
				end
				ST_PB_CHAN: begin
					state_next = ST_PB_CODE;
				end
				ST_PB_CODE: begin
					state_next = nest ? ST_DROP : ST_WDATA;
				end
				ST_WDATA: begin
					state_next = deny ? ST_DROP : ST_WDATA;
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// per-transaction context: target code, channel source, first data byte
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_code <= 8'h00;
			rail_mask_reg <= 2'h0;
			pb_mask_reg <= 2'h0;
			pb_mode_reg <= 1'b0;
			pb_rd_reg <= 1'b0;
			first_reg <= 1'b0;
		end else begin
			if (txn_start && !txn_rd) begin
				rail_mask_reg <= rail_hit;
				pb_mode_reg <= 1'b0;
			end
			if (code_ev) begin
				tgt_code <= wr_byte;
				pb_mode_reg <= pb_code;
				pb_rd_reg <= wr_byte == `PMPA_CMD_PB_READ;
				first_reg <= 1'b1;
			end
			if (wr_valid && state_reg == ST_PB_CHAN) begin
				pb_mask_reg <= chan_mask(wr_byte);
			end
			if (pb_ev && !nest) begin
				tgt_code <= wr_byte;
			end
			if (data_ev) begin
				first_reg <= 1'b0;
			end
		end
	end

	// channel select and protection level; paged block writes never touch select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel_reg <= `PMPA_RST_CHAN_SEL;
			wp_reg <= `PMPA_RST_WP_LEVEL;
		end else begin
			if (local_wr && !pb_mode_reg && tgt_code == `PMPA_CMD_CHAN_SEL) begin
				chan_sel_reg <= wr_byte;
			end
			if (local_wr && tgt_code == `PMPA_CMD_WP_LEVEL) begin
				wp_reg <= wr_byte & `PMPA_WP_KEEP_MASK;
			end
		end
	end

	// address setting and general configuration
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_addr_reg <= `PMPA_RST_DEV_ADDR;
			gcfg_reg <= `PMPA_RST_GLOBAL_CFG;
		end else begin
			if (local_wr && tgt_code == `PMPA_CMD_DEV_ADDR) begin
				dev_addr_reg <= wr_byte;
			end
			if (local_wr && tgt_code == `PMPA_CMD_GLOBAL_CFG) begin
				gcfg_reg <= wr_byte;
			end
		end
	end

	// paged registers: every selected channel takes the write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				ccfg_reg[i] <= `PMPA_RST_CHAN_CFG;
				rail_reg[i] <= `PMPA_RST_RAIL_ADDR;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (local_wr && eff_mask[i] && tgt_code == `PMPA_CMD_CHAN_CFG) begin
					ccfg_reg[i] <= wr_byte;
				end
				if (local_wr && eff_mask[i] && tgt_code == `PMPA_CMD_RAIL_ADDR) begin
					rail_reg[i] <= wr_byte;
				end
			end
		end
	end

	// answers: address hit, refusals, comms fault, forwarded data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_hit <= 1'b0;
			nack <= 1'b0;
			cml_fault <= 1'b0;
			fwd_valid <= 1'b0;
			fwd_data <= 8'h00;
			tgt_mask <= 2'h0;
		end else begin
			addr_hit <= txn_start && hit;
			nack <= deny || nest;
			cml_fault <= nest || (data_ev && tgt_code == `PMPA_CMD_CHAN_SEL && !chan_ok) ||
				(rd_contention && state_reg == ST_READ && |rail_mask_reg);
			fwd_valid <= data_ev && !deny && !is_local;
			fwd_data <= wr_byte;
			tgt_mask <= eff_mask;
		end
	end

	// read data; a paged block read sends its byte count first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			cnt_pend_reg <= 1'b0;
		end else begin
			rd_valid <= rd_req && state_reg == ST_READ;
			if (txn_start && txn_rd) begin
				cnt_pend_reg <= pb_mode_reg && pb_rd_reg;
			end else if (rd_req && state_reg == ST_READ) begin
				cnt_pend_reg <= 1'b0;
			end
			if (rd_req && state_reg == ST_READ) begin
				rd_data <= cnt_pend_reg ? `PMPA_PB_RD_COUNT : local_rd;
			end
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_nest;
		pb_ev && pb_code;
	endsequence
	sequence s_refuse;
		nack && cml_fault ##1 (state_reg == ST_DROP || state_reg == ST_IDLE);
	endsequence
	property p_nest;
		s_nest |=> s_refuse;
	endproperty
	a_nest: assert property (p_nest) else $error("nested paged block not refused");

	property p_chan_write;
		data_ev && first_reg && !pb_mode_reg && allowed && tgt_code == `PMPA_CMD_CHAN_SEL && wr_byte == `PMPA_CHAN_1
			|=> chan_sel_reg == `PMPA_CHAN_1 && !nack;
	endproperty
	a_chan_write: assert property (p_chan_write) else $error("channel select not stored");

	property p_pb_keep;
		pb_mode_reg && data_ev |=> $stable(chan_sel_reg);
	endproperty
	a_pb_keep: assert property (p_pb_keep) else $error("paged block changed select");

	property p_pin_block;
		data_ev && protect_pin && tgt_code == `PMPA_CMD_VOUT_SET |=> nack && !fwd_valid;
	endproperty
	a_pin_block: assert property (p_pin_block) else $error("pin did not block write");

	property p_lock;
		data_ev && !protect_pin && wp_reg[`PMPA_WP_LOCK_BIT] && tgt_code == `PMPA_CMD_OPERATION |=> nack;
	endproperty
	a_lock: assert property (p_lock) else $error("locked level let write pass");

	property p_ctrl;
		data_ev && !protect_pin && wp_reg == 8'h40 && tgt_code == `PMPA_CMD_OPERATION |=> fwd_valid && !nack;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control level blocked operation");

	property p_vout;
		data_ev && !protect_pin && wp_reg == 8'h20 && tgt_code == `PMPA_CMD_VOUT_SET |=> fwd_valid;
	endproperty
	a_vout: assert property (p_vout) else $error("vout level blocked setpoint");

	property p_status;
		data_ev && is_status(tgt_code) && (protect_pin || (!wp_reg[`PMPA_WP_LOCK_BIT] && wp_reg[6:5] != 2'h0))
			|=> fwd_valid;
	endproperty
	a_status: assert property (p_status) else $error("status clear blocked");

	property p_global;
		txn_start && txn_addr == `PMPA_GLOBAL_A |=> addr_hit;
	endproperty
	a_global: assert property (p_global) else $error("global address missed");

	property p_nonpaged;
		state_reg == ST_WDATA && tgt_code == `PMPA_CMD_WP_LEVEL ##1 state_reg == ST_WDATA |=> tgt_mask == 2'h3;
	endproperty
	a_nonpaged: assert property (p_nonpaged) else $error("channel applied to device command");
endmodule

`default_nettype wire

// >>> logic/pmpa_regs.svh
// command codes, reset values and field positions of the paging/address/protect block
// assumes plain `define use by every file that includes it
`ifndef PMPA_REGS_SVH
`define PMPA_REGS_SVH

// command codes decoded or held locally
`define PMPA_CMD_CHAN_SEL 8'h00
`define PMPA_CMD_OPERATION 8'h01
`define PMPA_CMD_ON_OFF_CFG 8'h02
`define PMPA_CMD_CLR_FAULTS 8'h03
`define PMPA_CMD_PB_WRITE 8'h05
`define PMPA_CMD_PB_READ 8'h06
`define PMPA_CMD_WP_LEVEL 8'h10
`define PMPA_CMD_SAVE_NVM 8'h15
`define PMPA_CMD_VOUT_SET 8'h21
`define PMPA_CMD_STATUS_LO 8'h78
`define PMPA_CMD_STATUS_HI 8'h80
`define PMPA_CMD_NVM_UNLOCK 8'hbd
`define PMPA_CMD_CHAN_CFG 8'hd0
`define PMPA_CMD_GLOBAL_CFG 8'hd1
`define PMPA_CMD_PEAK_RST 8'he3
`define PMPA_CMD_DEV_ADDR 8'he6
`define PMPA_CMD_COMMON_STAT 8'hef
`define PMPA_CMD_RAIL_ADDR 8'hfa

// reset values
`define PMPA_RST_CHAN_SEL 8'h00
`define PMPA_RST_WP_LEVEL 8'h00
`define PMPA_RST_DEV_ADDR 8'h4f
`define PMPA_RST_RAIL_ADDR 8'h80
`define PMPA_RST_CHAN_CFG 8'h1d
`define PMPA_RST_GLOBAL_CFG 8'h21

// channel select values
`define PMPA_CHAN_0 8'h00
`define PMPA_CHAN_1 8'h01
`define PMPA_CHAN_ALL 8'hff

// protection level fields; low five bits are reserved
`define PMPA_WP_LOCK_BIT 7
`define PMPA_WP_CTRL_BIT 6
`define PMPA_WP_VOUT_BIT 5
`define PMPA_WP_KEEP_MASK 8'he0

// addressing
`define PMPA_ADDR_OFF 8'h80
`define PMPA_GLOBAL_A 7'h5a
`define PMPA_GLOBAL_B 7'h5b
`define PMPA_LOW_BITS 4
`define PMPA_HIGH_BITS 3

// common status byte: protect pin state position
`define PMPA_CSB_PIN_BIT 0
// block count returned ahead of paged block read data
`define PMPA_PB_RD_COUNT 8'h01

`endif

// >>> logic/pmpa_pkg.sv
// types of the paging/address/protect block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package pmpa_pkg;
	// command-layer transaction state
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CODE,
		ST_WDATA,
		ST_PB_CNT,
		ST_PB_CHAN,
		ST_PB_CODE,
		ST_READ,
		ST_DROP
	} pmpa_state_t;
endpackage

`default_nettype wire

// >>> logic/pmpa_addr_match.sv
// address match: effective device address from pins and stored setting, globals, rail
// assumes the address byte is presented for one cycle by the link layer
`include "pmpa_regs.svh"
`default_nettype none

module pmpa_addr_match
	import pmpa_pkg::*;
(
	// address under test
	input wire logic [6:0] txn_addr,
	// stored settings
	input wire logic [7:0] dev_addr_set,
	input wire logic [7:0] rail_addr_0,
	input wire logic [7:0] rail_addr_1,
	// strap pins with open detection
	input wire logic [3:0] addr_select_low_pin,
	input wire logic addr_select_low_open,
	input wire logic [2:0] addr_select_high_pin,
	input wire logic addr_select_high_open,
	// results
	output logic hit,
	output logic [1:0] rail_hit
);
	logic [3:0] eff_low;
	logic [2:0] eff_high;
	logic [6:0] eff_addr;
	logic dev_on;
	logic glob_hit;

	// pins win over storage, open pins fall back to storage bits
	assign eff_low = addr_select_low_open ? dev_addr_set[3:0] : addr_select_low_pin;
	assign eff_high = addr_select_high_open ? dev_addr_set[6:4] : addr_select_high_pin;
	assign eff_addr = {eff_high, eff_low};
	assign dev_on = dev_addr_set != `PMPA_ADDR_OFF;
	assign glob_hit = (txn_addr == `PMPA_GLOBAL_A) || (txn_addr == `PMPA_GLOBAL_B);

	// rail address per channel, off at its disable value
	assign rail_hit[0] = (rail_addr_0 != `PMPA_RST_RAIL_ADDR) && (txn_addr == rail_addr_0[6:0]);
	assign rail_hit[1] = (rail_addr_1 != `PMPA_RST_RAIL_ADDR) && (txn_addr == rail_addr_1[6:0]);
	assign hit = glob_hit || (dev_on && txn_addr == eff_addr) || (|rail_hit);
endmodule

`default_nettype wire

// >>> bench/pmpa_host_model.sv
// host model: issues front end events, one per cycle, after a chosen idle gap
// assumes a single caller process and events launched just after the rising edge
`default_nettype none

module pmpa_host_model (
	// clock
	input wire logic core_clk,
	// event lines
	output logic txn_start,
	output logic txn_rd,
	output logic [6:0] txn_addr,
	output logic txn_stop,
	output logic wr_valid,
	output logic [7:0] wr_byte,
	output logic rd_req,
	output logic rd_contention
);
	timeunit 1ns;
	timeprecision 1ns;

	// quiet lines at time zero
	initial begin
		{txn_start, txn_rd, txn_stop, wr_valid, rd_req, rd_contention} = 6'h00;
		txn_addr = 7'h00;
		wr_byte = 8'h00;
	end

	// k: 1 start write, 2 start read, 3 byte, 4 read request, 5 stop, 6 contention
	// stale data lines are inverted so an unqualified value never looks reusable
	task automatic ev(input logic [2:0] k, input logic [7:0] b, input int g);
		for (int i = 0; i <= g; i++) begin
			@(posedge core_clk);
			#2;
			txn_start = (i == g) && (k == 3'h1 || k == 3'h2);
			txn_rd = (i == g) && (k == 3'h2);
			txn_addr = txn_start ? b[6:0] : ~txn_addr;
			wr_valid = (i == g) && (k == 3'h3);
			wr_byte = wr_valid ? b : ~wr_byte;
			rd_req = (i == g) && (k == 3'h4);
			txn_stop = (i == g) && (k == 3'h5);
			rd_contention = (i == g) && (k == 3'h6);
		end
	endtask
endmodule

`default_nettype wire

// >>> bench/pmpa_cmd_core_bench.sv
// self-checking bench of the command core: paging, paged blocks, protection, addressing
// assumes the design files compile first; notes are matched in order by a monitor
`default_nettype none

module pmpa_cmd_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_n, protect_pin, lo_open, hi_open;
	logic [3:0] lo_pin;
	logic [2:0] hi_pin;
	logic [7:0] ext_rd_data, rd_data, fwd_data, wr_byte, d;
	logic txn_start, txn_rd, txn_stop, wr_valid, rd_req, rd_contention;
	logic [6:0] txn_addr, dev;
	logic addr_hit, nack, cml_fault, rd_valid, fwd_valid;
	logic [7:0] tgt_code;
	logic [1:0] tgt_mask;
	logic [31:0] q[$];
	int failures = 0;
	int num_checks = 0;
	int seed;
	logic [7:0] rc [6] = '{8'h00, 8'h10, 8'he6, 8'hd1, 8'hd0, 8'hfa};
	logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h4f, 8'h21, 8'h1d, 8'h80};
	logic [7:0] lv [5] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00};
	logic [7:0] wc [6] = '{8'h01, 8'h02, 8'h21, 8'hbd, 8'h78, 8'h35};
	logic [5:0] okm [5] = '{6'h08, 6'h19, 6'h1f, 6'h3f, 6'h19};

	// core clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	pmpa_host_model u_host (.core_clk(core_clk), .txn_start(txn_start), .txn_rd(txn_rd), .txn_addr(txn_addr),
		.txn_stop(txn_stop), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req), .rd_contention(rd_contention));

	pmpa_cmd_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .txn_start(txn_start), .txn_rd(txn_rd),
		.txn_addr(txn_addr), .txn_stop(txn_stop), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
		.rd_contention(rd_contention), .protect_pin(protect_pin), .addr_select_low_pin(lo_pin),
		.addr_select_low_open(lo_open), .addr_select_high_pin(hi_pin), .addr_select_high_open(hi_open),
		.ext_rd_data(ext_rd_data), .addr_hit(addr_hit), .nack(nack), .cml_fault(cml_fault), .rd_valid(rd_valid),
		.rd_data(rd_data), .fwd_valid(fwd_valid), .fwd_data(fwd_data), .tgt_code(tgt_code), .tgt_mask(tgt_mask));

	// note: {care mask, kind, value}; kinds 1 read, 2 refusal, 3 forward, 4 address hit, 5 fault,
	// 6 forwarded target code, 7 forwarded channel mask
	task automatic note(input logic [7:0] t, input logic [7:0] v, input logic [15:0] m);
		q.push_back({m, t, v});
	endtask

	task automatic see(input logic [7:0] t, input logic [7:0] v);
		logic [31:0] x;
		num_checks++;
		x = (q.size() != 0) ? q.pop_front() : 32'hffff_0000;
		if (((({t, v}) ^ x[15:0]) & x[31:16]) !== 16'h0000) begin
			failures++;
			$display("[ERR] result expected %h seen %h", x[15:0], {t, v});
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic e(input logic [2:0] k, input logic [7:0] b, input int g = 0);
		u_host.ev(k, b, g);
	endtask

	// res: 0 refused, 1 accepted, 2 refused with fault; only non-local codes are forwarded
	task automatic expect_w(input logic [7:0] c, input logic [7:0] v, input int res);
		if (res == 0)
			note(8'h02, 8'h00, 16'hffff);
		else if (res == 2)
			note(8'h02, 8'h01, 16'hffff);
		else if (!(c inside {8'h00, 8'h10, 8'he6, 8'hd0, 8'hd1, 8'hfa})) begin
			note(8'h03, v, 16'hffff);
			note(8'h06, c, 16'hffff);
			// forwarded writes all run with channel 0 selected; device-wide codes address both
			note(8'h07, (c inside {8'h03, 8'h15, 8'hbd, 8'he3}) ? 8'h03 : 8'h01, 16'hffff);
		end
	endtask

	task automatic wr(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] v, input int res, input logic hit);
		if (hit) begin
			note(8'h04, 8'h00, 16'hffff);
			expect_w(c, v, res);
		end
		e(3'h1, {1'b0, ad});
		e(3'h3, c);
		e(3'h3, v);
		e(3'h5, 8'h00);
	endtask

	task automatic rd(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] v, input int g);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h01, v, 16'hffff);
		e(3'h1, {1'b0, ad});
		e(3'h3, c);
		e(3'h2, {1'b0, ad}, g);
		e(3'h4, 8'h00);
		e(3'h5, 8'h00);
	endtask

	// paged block write: count 3 covers channel, code and one data byte
	task automatic pbw(input logic [7:0] ch, input logic [7:0] c, input logic [7:0] v, input int res);
		note(8'h04, 8'h00, 16'hffff);
		expect_w(c, v, res);
		e(3'h1, {1'b0, dev});
		e(3'h3, 8'h05);
		e(3'h3, 8'h03);
		e(3'h3, ch);
		e(3'h3, c);
		e(3'h3, v);
		e(3'h5, 8'h00);
	endtask

	// paged block read: answer is a count of one, then the data byte
	task automatic pbr(input logic [7:0] ch, input logic [7:0] c, input logic [7:0] v);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h01, 8'h01, 16'hffff);
		note(8'h01, v, 16'hffff);
		e(3'h1, {1'b0, dev});
		e(3'h3, 8'h06);
		e(3'h3, 8'h02);
		e(3'h3, ch);
		e(3'h3, c);
		e(3'h2, {1'b0, dev});
		e(3'h4, 8'h00);
		e(3'h4, 8'h00);
		e(3'h5, 8'h00);
	endtask

	// monitor: every result pulse takes the oldest note
	always @(negedge core_clk) begin
		if (rst_n === 1'b1) begin
			if (addr_hit !== 1'b0) see(8'h04, 8'h00);
			if (rd_valid !== 1'b0) see(8'h01, rd_data);
			if (nack !== 1'b0) see(8'h02, {7'h00, cml_fault});
			if (fwd_valid !== 1'b0) begin
				see(8'h03, fwd_data);
				see(8'h06, tgt_code);
				see(8'h07, {6'h00, tgt_mask});
			end
			if (cml_fault !== 1'b0 && nack !== 1'b1) see(8'h05, 8'h00);
		end
	end

	// main sequence
	initial begin
		seed = 32'h1d83;
		{rst_n, protect_pin, lo_pin, hi_pin} = 9'h000;
		{lo_open, hi_open} = 2'h3;
		ext_rd_data = 8'hc3;
		dev = 7'h4f;
		repeat (6) @(posedge core_clk);
		#2 rst_n = 1'b1;
		for (int i = 0; i < 6; i++) rd(dev, rc[i], rv[i], i);
		wr(dev, 8'h00, 8'h01, 1, 1);
		wr(dev, 8'hd0, 8'h11, 1, 1);
		rd(dev, 8'hd0, 8'h11, 0);
		wr(dev, 8'h00, 8'h00, 1, 1);
		rd(dev, 8'hd0, 8'h1d, 0);
		wr(dev, 8'h00, 8'hff, 1, 1);
		wr(dev, 8'hd0, 8'h55, 1, 1);
		wr(dev, 8'h00, 8'h01, 1, 1); // reads only after leaving broadcast
		rd(dev, 8'hd0, 8'h55, 2);
		wr(dev, 8'h00, 8'h02, 2, 1);
		rd(dev, 8'h00, 8'h01, 0);
		wr(dev, 8'h00, 8'h00, 1, 1);
		pbw(8'h01, 8'hd0, 8'h33, 1);
		rd(dev, 8'h00, 8'h00, 0);
		pbr(8'h01, 8'hd0, 8'h33);
		pbr(8'h00, 8'hd0, 8'h55);
		pbr(8'h01, 8'hd1, 8'h21);
		pbw(8'h01, 8'h06, 8'h00, 2);
		for (int j = 0; j < 5; j++) begin
			protect_pin = (j == 4);
			wr(dev, 8'h10, lv[j], 1, 1); // reserved bits kept zero
			for (int k = 0; k < 6; k++) begin
				d = 8'($random(seed));
				wr(dev, wc[k], d, int'(okm[j][k]), 1);
			end
			d = 8'($random(seed));
			pbw(8'h00, 8'h21, d, int'(okm[j][2]));
		end
		rd(dev, 8'h10, 8'h00, 0);
		rd(dev, 8'hef, 8'h01, 1);
		ext_rd_data = 8'($random(seed));
		rd(dev, 8'h21, ext_rd_data, 0);
		protect_pin = 1'b0;
		wr(7'h6e, 8'h00, 8'h01, 1, 0);
		rd(dev, 8'h00, 8'h00, 0);
		lo_pin = 4'($random(seed));
		hi_pin = 3'($random(seed));
		{lo_open, hi_open} = 2'h0;
		rd({hi_pin, lo_pin}, 8'h00, 8'h00, 0);
		lo_open = 1'b1;
		rd({hi_pin, 4'hf}, 8'h00, 8'h00, 0);
		{lo_open, hi_open} = 2'h1;
		rd({3'h4, lo_pin}, 8'h00, 8'h00, 0);
		lo_open = 1'b1;
		wr(dev, 8'he6, 8'h80, 1, 1);
		wr(dev, 8'h00, 8'h01, 1, 0);
		rd(7'h5a, 8'h00, 8'h00, 0);
		rd(7'h5b, 8'he6, 8'h80, 0);
		wr(7'h5a, 8'hfa, 8'h30, 1, 1);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h04, 8'h00, 16'hffff);
		note(8'h01, 8'h55, 16'hffff);
		note(8'h05, 8'h00, 16'hffff);
		e(3'h1, 8'h30);
		e(3'h3, 8'hd0);
		e(3'h2, 8'h30);
		e(3'h4, 8'h00);
		e(3'h6, 8'h00);
		e(3'h5, 8'h00);
		repeat (4) @(posedge core_clk);
		if (q.size() != 0) begin
			failures++;
			$display("[ERR] pending expected 0 seen %0d", q.size());
		end
		close_out();
	end

	// watchdog well beyond the expected run of about four hundred cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		close_out();
	end
endmodule

`default_nettype wire
